// ===== rtl/asu_pkg.sv
/*
 * asu_pkg: register map, field positions, reset values, frame encodings
 * and state types of the asynchronous serial channel.
 * Assumes one 8-bit register port with 3 address bits.
 */
package asu_pkg;
    // register indices on the 3-bit register port
    localparam logic [2:0] ADDR_MODE = 3'h0; // frame format and sleep
    localparam logic [2:0] ADDR_CTRL0 = 3'h1; // handshake select, status
    localparam logic [2:0] ADDR_CTRL1 = 3'h2; // enables and flags
    localparam logic [2:0] ADDR_TXBUF_LO = 3'h3; // tx data bits 7..0
    localparam logic [2:0] ADDR_TXBUF_HI = 3'h4; // tx data bit 8
    localparam logic [2:0] ADDR_RXBUF_LO = 3'h5; // rx data, read clears
    localparam logic [2:0] ADDR_RXBUF_HI = 3'h6; // rx data bit 8
    localparam logic [2:0] ADDR_BRG = 3'h7; // bit-rate divisor n
    // mode register fields
    localparam int MODE_EXT_CLK = 3; // 1 = external bit-rate clock
    localparam int MODE_TWO_STOP = 4; // 1 = two stop bits
    localparam int MODE_EVEN = 5; // 1 = even parity, 0 = odd
    localparam int MODE_PAR_EN = 6; // 1 = parity bit appended
    localparam int MODE_SLEEP = 7; // 1 = sleep mode
    // data length codes in mode bits 2..0
    localparam logic [2:0] LEN_7 = 3'h4;
    localparam logic [2:0] LEN_8 = 3'h5;
    localparam logic [2:0] LEN_9 = 3'h6;
    // control register 0 fields
    localparam int C0_HS_SEL = 2; // 0 = clear-to-send, 1 = request-to-send
    localparam int C0_SHIFT_EMPTY = 3; // read only
    // control register 1 fields
    localparam int C1_TX_EN = 0;
    localparam int C1_RX_EN = 2;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] BRG_RST = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h7; // lines idle high
    // sixteen subperiods per bit
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    // transmitter and receiver states
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
    } asu_tx_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
    } asu_rx_t;
endpackage : asu_pkg

// ===== rtl/asu_uart.sv
/*
 * asu_uart: asynchronous serial transmitter and receiver with optional
 * clear-to-send / request-to-send handshake and multiprocessor sleep mode.
 * Assumes a single clock, a register master that never needs wait states,
 * and interrupt control registers outside that take the request pulses.
 */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module asu_uart (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic ext_bit_clk,
    input wire logic clear_to_send_in,
    output logic request_to_send_out,
    output logic request_to_send_oe,
    output logic tx_int_req,
    output logic rx_int_req
);
    // three-stage synchronisers: bit 2 ext clock, 1 cts, 0 rx line
    logic [2:0] sync1, sync2, sync3, filt;
    wire [2:0] raw = {ext_bit_clk, clear_to_send_in, serial_in_pin};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            // level accepted once stages two and three agree
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sync1[g] <= 1'b1;
                    sync2[g] <= 1'b1;
                    sync3[g] <= 1'b1;
                    filt[g] <= 1'b1;
                end else begin
                    sync1[g] <= raw[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g]) filt[g] <= sync3[g];
                end
            end
        end
    endgenerate
    wire ext_rise = sync2[2] & sync3[2] & ~filt[2]; // accepted rising edge
    wire cts_lvl = filt[1];
    wire rx_lvl = filt[0];

    // software registers
    logic [7:0] mode; // format, clock source, sleep
    logic [7:0] brg; // divisor n
    logic hs_sel, tx_en, rx_en;
    logic [8:0] txbuf, rxbuf;
    logic tx_empty, tx_shift_empty_flag;
    logic full, ovr, frm, par, sum; // rx flags

    // register decode
    wire wr_mode = wr && addr == asu_pkg::ADDR_MODE;
    wire wr_c0 = wr && addr == asu_pkg::ADDR_CTRL0;
    wire wr_c1 = wr && addr == asu_pkg::ADDR_CTRL1;
    wire wr_txlo = wr && addr == asu_pkg::ADDR_TXBUF_LO;
    wire wr_txhi = wr && addr == asu_pkg::ADDR_TXBUF_HI;
    wire wr_brg = wr && addr == asu_pkg::ADDR_BRG;
    wire rd_rxlo = rd && addr == asu_pkg::ADDR_RXBUF_LO;

    // frame format
    wire len7 = mode[2:0] == asu_pkg::LEN_7;
    wire len9 = mode[2:0] == asu_pkg::LEN_9;
    wire [3:0] dlen = len7 ? 4'h7 : (len9 ? 4'h9 : 4'h8);
    wire [8:0] dmask = len7 ? 9'h07F : (len9 ? 9'h1FF : 9'h0FF);
    wire two_stop = mode[asu_pkg::MODE_TWO_STOP];
    wire par_en = mode[asu_pkg::MODE_PAR_EN];
    wire odd_sel = ~mode[asu_pkg::MODE_EVEN];
    wire sleep = mode[asu_pkg::MODE_SLEEP];

    // software writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= asu_pkg::MODE_RST;
            brg <= asu_pkg::BRG_RST;
            hs_sel <= 1'b0;
            tx_en <= 1'b0;
            rx_en <= 1'b0;
            txbuf <= 9'h000;
        end else begin
            if (wr_mode) mode <= wdata;
            if (wr_brg) brg <= wdata;
            if (wr_c0) hs_sel <= wdata[asu_pkg::C0_HS_SEL];
            if (wr_c1) begin
                tx_en <= wdata[asu_pkg::C1_TX_EN];
                rx_en <= wdata[asu_pkg::C1_RX_EN];
            end
            if (wr_txlo) txbuf[7:0] <= wdata;
            if (wr_txhi) txbuf[8] <= wdata[0];
        end
    end

    // divider source: every clock or accepted external edge
    wire src_tick = mode[asu_pkg::MODE_EXT_CLK] ? ext_rise : 1'b1;
    logic [7:0] tx_pre, rx_pre;
    logic [3:0] tx_sub, rx_sub, tx_cnt, rx_cnt;
    asu_pkg::asu_tx_t tx_state;
    asu_pkg::asu_rx_t rx_state;
    wire tx_tick = src_tick && tx_pre == brg; // divide by n+1
    wire rx_tick = src_tick && rx_pre == brg;
    wire tx_bit_end = tx_tick && tx_sub == asu_pkg::SUB_LAST;
    wire rx_mid = rx_tick && rx_sub == asu_pkg::SUB_MID;

    // transmitter start logic
    wire tx_last_stop = tx_state == asu_pkg::TX_STOP2 ||
        (tx_state == asu_pkg::TX_STOP1 && !two_stop);
    wire tx_end_window = tx_state == asu_pkg::TX_IDLE ||
        (tx_last_stop && tx_bit_end);
    wire tx_go = tx_en && !tx_empty && (hs_sel || !cts_lvl);
    wire tx_start = tx_end_window && tx_go;
    wire tx_from_idle = tx_start && tx_state == asu_pkg::TX_IDLE;
    logic [8:0] tx_sh;
    logic tx_pbit;
    wire next_tx_empty = wr_txlo ? 1'b0 : (tx_start ? 1'b1 : tx_empty);

    // tx bit timing; restarts only when leaving idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_pre <= 8'h00;
            tx_sub <= 4'h0;
        end else if (tx_from_idle) begin
            tx_pre <= 8'h00;
            tx_sub <= 4'h0;
        end else if (src_tick) begin
            tx_pre <= tx_tick ? 8'h00 : tx_pre + 8'h01;
            if (tx_tick) tx_sub <= tx_sub + 4'h1;
        end
    end

    // transmit frame sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= asu_pkg::TX_IDLE;
            tx_sh <= 9'h000;
            tx_pbit <= 1'b0;
            tx_cnt <= 4'h0;
        end else begin
            if (tx_start) begin
                // load shift register, reload back to back
                tx_state <= asu_pkg::TX_START;
                tx_sh <= txbuf & dmask;
                tx_pbit <= (^(txbuf & dmask)) ^ odd_sel;
            end else if (tx_bit_end) begin
                // enable and handshake not looked at here
                case (tx_state)
                    asu_pkg::TX_START: begin
                        tx_state <= asu_pkg::TX_DATA;
                        tx_cnt <= 4'h0;
                    end
                    asu_pkg::TX_DATA: begin
                        tx_sh <= {1'b0, tx_sh[8:1]}; // lsb first
                        tx_cnt <= tx_cnt + 4'h1;
                        if (tx_cnt == dlen - 4'h1) begin
                            tx_state <= par_en ? asu_pkg::TX_PAR
                                : asu_pkg::TX_STOP1;
                        end
                    end
                    asu_pkg::TX_PAR: tx_state <= asu_pkg::TX_STOP1;
                    asu_pkg::TX_STOP1: begin
                        tx_state <= two_stop ? asu_pkg::TX_STOP2
                            : asu_pkg::TX_IDLE;
                    end
                    default: tx_state <= asu_pkg::TX_IDLE;
                endcase
            end
        end
    end

    // line level per state
    wire next_txd = (tx_state == asu_pkg::TX_START) ? 1'b0 :
        (tx_state == asu_pkg::TX_DATA) ? tx_sh[0] :
        (tx_state == asu_pkg::TX_PAR) ? tx_pbit : 1'b1;

    // tx flags, line and interrupt request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_empty <= 1'b1;
            tx_shift_empty_flag <= 1'b1;
            tx_int_req <= 1'b0;
            serial_out_pin <= 1'b1; // line idles high
        end else begin
            tx_empty <= next_tx_empty;
            tx_int_req <= next_tx_empty & ~tx_empty;
            if (tx_start) tx_shift_empty_flag <= 1'b0;
            else if (tx_end_window) tx_shift_empty_flag <= 1'b1;
            serial_out_pin <= next_txd;
        end
    end

    // receiver decode
    wire rx_detect = rx_state == asu_pkg::RX_IDLE && rx_en && !rx_lvl;
    wire rx_done = rx_mid && (rx_state == asu_pkg::RX_STOP2 ||
        (rx_state == asu_pkg::RX_STOP1 && !two_stop));
    logic [8:0] rx_sh;
    logic rx_pbit, rx_fe, rts_busy;
    wire rx_top = len7 ? rx_sh[6] : (len9 ? rx_sh[8] : rx_sh[7]);
    // a frame ending as the receiver is disabled is dropped
    wire rx_load = rx_done && rx_en && (!sleep || rx_top);
    wire fe_now = rx_fe | !rx_lvl;
    wire pe_now = par_en && ((^(rx_sh & dmask)) ^ rx_pbit ^ odd_sel);
    wire rx_clr = rd_rxlo || !rx_en;

    // rx bit timing, held at zero until a start bit arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_pre <= 8'h00;
            rx_sub <= 4'h0;
        end else if (rx_state == asu_pkg::RX_IDLE) begin
            rx_pre <= 8'h00;
            rx_sub <= 4'h0;
        end else if (src_tick) begin
            rx_pre <= rx_tick ? 8'h00 : rx_pre + 8'h01;
            if (rx_tick) rx_sub <= rx_sub + 4'h1;
        end
    end

    // receive frame sequencer, samples at mid bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= asu_pkg::RX_IDLE;
            rx_sh <= 9'h000;
            rx_pbit <= 1'b0;
            rx_fe <= 1'b0;
            rx_cnt <= 4'h0;
        end else if (!rx_en) begin
            rx_state <= asu_pkg::RX_IDLE; // disable aborts a frame
        end else if (rx_detect) begin
            rx_state <= asu_pkg::RX_START;
            rx_sh <= 9'h000;
            rx_fe <= 1'b0;
        end else if (rx_mid) begin
            case (rx_state)
                asu_pkg::RX_START: begin
                    // glitch shorter than half a bit is dropped
                    rx_state <= rx_lvl ? asu_pkg::RX_IDLE : asu_pkg::RX_DATA;
                    rx_cnt <= 4'h0;
                end
                asu_pkg::RX_DATA: begin
                    rx_sh[rx_cnt] <= rx_lvl;
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == dlen - 4'h1) begin
                        rx_state <= par_en ? asu_pkg::RX_PAR
                            : asu_pkg::RX_STOP1;
                    end
                end
                asu_pkg::RX_PAR: begin
                    rx_pbit <= rx_lvl;
                    rx_state <= asu_pkg::RX_STOP1;
                end
                asu_pkg::RX_STOP1: begin
                    rx_fe <= !rx_lvl;
                    rx_state <= two_stop ? asu_pkg::RX_STOP2
                        : asu_pkg::RX_IDLE;
                end
                default: rx_state <= asu_pkg::RX_IDLE;
            endcase
        end
    end

    // flag next values; a load wins over a clear
    wire next_full = rx_load | (full & !rx_clr);
    wire next_ovr = (rx_load & full & !rd_rxlo) | (ovr & !rx_clr);
    wire next_frm = (rx_load & fe_now) | (frm & !rx_clr);
    wire next_par = (rx_load & pe_now) | (par & !rx_clr);
    wire next_rts_busy = rx_en && (rx_detect ||
        (rts_busy && !rx_done && rx_state != asu_pkg::RX_IDLE));

    // receive buffer, flags, request-to-send, interrupt request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxbuf <= 9'h000;
            {full, ovr, frm, par, sum} <= 5'h00;
            rx_int_req <= 1'b0;
            rts_busy <= 1'b0;
            request_to_send_out <= 1'b1;
            request_to_send_oe <= 1'b0;
        end else begin
            if (rx_load) rxbuf <= rx_sh & dmask;
            full <= next_full;
            ovr <= next_ovr;
            frm <= next_frm;
            par <= next_par;
            sum <= next_ovr | next_frm | next_par;
            rx_int_req <= next_full & ~full;
            rts_busy <= next_rts_busy;
            request_to_send_out <= !rx_en || rts_busy;
            request_to_send_oe <= hs_sel;
        end
    end

    // read selection; data valid only the cycle after the strobe
    wire [7:0] c0_rd = {4'h0, tx_shift_empty_flag, hs_sel, 2'h0};
    wire [7:0] c1_rd = {sum, par, frm, ovr, full, rx_en, tx_empty, tx_en};
    wire [7:0] rd_mux = (addr == asu_pkg::ADDR_MODE) ? mode :
        (addr == asu_pkg::ADDR_CTRL0) ? c0_rd :
        (addr == asu_pkg::ADDR_CTRL1) ? c1_rd :
        (addr == asu_pkg::ADDR_RXBUF_LO) ? rxbuf[7:0] :
        (addr == asu_pkg::ADDR_RXBUF_HI) ? {7'h00, rxbuf[8]} :
        (addr == asu_pkg::ADDR_BRG) ? brg : 8'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rdata <= 8'h00;
        else rdata <= rd ? rd_mux : 8'h00;
    end

    // checks
    property p_tx_start;
        @(posedge clk) disable iff (rst)
        (tx_state == asu_pkg::TX_IDLE ##1 tx_state == asu_pkg::TX_START)
        |-> $past(tx_en) && !$past(tx_empty) &&
            ($past(hs_sel) || !$past(cts_lvl));
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("frame started without start condition");
    property p_tx_hold;
        @(posedge clk) disable iff (rst)
        (tx_state == asu_pkg::TX_DATA && !tx_en)
        |=> tx_state != asu_pkg::TX_IDLE;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("frame cut short");
    property p_tx_wr;
        @(posedge clk) disable iff (rst) wr_txlo |=> !tx_empty;
    endproperty
    a_tx_wr: assert property (p_tx_wr)
        else $error("buffer-empty not cleared by write");
    property p_shift_empty;
        @(posedge clk) disable iff (rst)
        (tx_end_window && !tx_start) |=> tx_shift_empty_flag;
    endproperty
    a_shift_empty: assert property (p_shift_empty)
        else $error("shift-empty not set after window");
    property p_tx_irq;
        @(posedge clk) disable iff (rst)
        (!tx_empty ##1 tx_empty) |-> tx_int_req;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("no tx interrupt request");
    property p_ovr;
        @(posedge clk) disable iff (rst)
        (rx_load && full && !rd_rxlo) |=> ovr && full && sum;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("overrun not flagged");
    property p_sum;
        @(posedge clk) disable iff (rst) sum == (ovr | frm | par);
    endproperty
    a_sum: assert property (p_sum)
        else $error("summary flag mismatch");
    property p_sleep;
        @(posedge clk) disable iff (rst)
        (rx_done && sleep && !rx_top && !rx_clr)
        |=> $stable(full) && $stable(rxbuf);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleeping receiver took frame");
    property p_rts;
        @(posedge clk) disable iff (rst)
        (hs_sel && !rx_en) |=> request_to_send_out;
    endproperty
    a_rts: assert property (p_rts)
        else $error("request-to-send low while disabled");
    property p_clr;
        @(posedge clk) disable iff (rst)
        (rd_rxlo && !rx_load) |=> !full && !sum;
    endproperty
    a_clr: assert property (p_clr)
        else $error("flags not cleared by read");
endmodule : asu_uart

// ===== tb/asu_peer.sv
/*
 * asu_peer: remote asynchronous transceiver facing the serial channel.
 * Assumes the bench sets fmt to the mode value and brg so that the bit
 * time, sixteen clocks times brg plus one, matches the device's.
 */
`timescale 1ns/1ps
module asu_peer (
    input wire logic clk,
    input wire logic [7:0] fmt,
    input wire logic [7:0] brg,
    input wire logic line_in,
    output logic line_out,
    output logic got,
    output logic [9:0] got_word
);
    // line idles high, decoder outputs quiet
    initial begin
        line_out = 1'b1;
        got = 1'b0;
        got_word = 10'h000;
    end
    // data length from the mode code
    function automatic int nbits(input logic [2:0] c);
        return (c == asu_pkg::LEN_7) ? 7 : (c == asu_pkg::LEN_9) ? 9 : 8;
    endfunction : nbits
    // one bit held for a whole bit time
    task automatic bit_out(input logic b);
        line_out <= b;
        repeat (16 * (brg + 1)) @(posedge clk);
    endtask : bit_out
    // sends one frame in the shared format; data must fit the length
    task automatic send(input logic [8:0] d, input logic bad_par,
                        input logic bad_stop);
        @(posedge clk);
        bit_out(1'b0);
        for (int i = 0; i < nbits(fmt[2:0]); i++) begin
            bit_out(d[i]);
        end
        if (fmt[asu_pkg::MODE_PAR_EN]) begin
            bit_out(^d ^ ~fmt[asu_pkg::MODE_EVEN] ^ bad_par);
        end
        bit_out(~bad_stop);
        if (fmt[asu_pkg::MODE_TWO_STOP]) begin
            bit_out(1'b1);
        end
        line_out <= 1'b1;
    endtask : send
    // decoder: mid-bit samples, reports data and frame soundness
    always begin : decode
        logic [8:0] d;
        logic ok;
        @(negedge line_in);
        d = 9'h000;
        repeat (8 * (brg + 1)) @(posedge clk);
        ok = ~line_in;
        for (int i = 0; i < nbits(fmt[2:0]); i++) begin
            repeat (16 * (brg + 1)) @(posedge clk);
            d[i] = line_in;
        end
        if (fmt[asu_pkg::MODE_PAR_EN]) begin
            repeat (16 * (brg + 1)) @(posedge clk);
            ok = ok & (line_in == (^d ^ ~fmt[asu_pkg::MODE_EVEN]));
        end
        repeat (16 * (brg + 1)) @(posedge clk);
        ok = ok & line_in;
        if (fmt[asu_pkg::MODE_TWO_STOP]) begin
            repeat (16 * (brg + 1)) @(posedge clk);
            ok = ok & line_in;
        end
        got_word <= {ok, d};
        got <= 1'b1;
        @(posedge clk);
        got <= 1'b0;
    end
endmodule : asu_peer

// ===== tb/tb.sv
/*
 * tb: self-checking bench for the serial channel. Reads note expected
 * data in a queue, a watcher compares rdata one cycle later; frames sent
 * by the device are decoded by the peer and matched against a queue.
 * Assumes asu_pkg, asu_uart and asu_peer are compiled first.
 */
`timescale 1ns/1ps
module tb;
    localparam int LIMIT = 30000; // cycle ceiling
    // last format runs from the external source, one tick per 4 clocks
    localparam logic [7:0] FMTS [4] = '{8'h75, 8'h44, 8'h06, 8'h0D};
    localparam logic [8:0] MASKS [4] = '{9'h0FF, 9'h07F, 9'h1FF, 9'h0FF};
    localparam logic [7:0] BRGS [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    localparam int FLEN [4] = '{192, 160, 352, 640}; // clocks per frame
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cts = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] fmt = 8'h00;
    logic [7:0] brg = 8'h00;
    logic [7:0] rdata;
    logic sin, sout, rts, rts_oe, tx_irq, rx_irq, got;
    logic rd_seen = 1'b0;
    logic [9:0] got_word;
    logic [31:0] lfsr = 32'h8FAAB41D;
    logic [1:0] ext_div = 2'h0; // external bit-rate source, clk over 4
    logic [7:0] rd_q [$]; // expected read data
    logic [9:0] tx_q [$]; // expected {sound, data} of sent frames
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n_rxi = 0;
    int txi_at = 0;
    int txi_gap = 0;

    asu_uart dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .serial_in_pin(sin),
        .serial_out_pin(sout), .ext_bit_clk(ext_div[1]),
        .clear_to_send_in(cts), .request_to_send_out(rts),
        .request_to_send_oe(rts_oe), .tx_int_req(tx_irq),
        .rx_int_req(rx_irq));
    asu_peer peer_u (.clk(clk), .fmt(fmt), .brg(brg), .line_in(sout),
        .line_out(sin), .got(got), .got_word(got_word));

    // 40 MHz clock
    always #12.5 clk = ~clk;
    // free-running external source, two clocks high, two low
    always @(posedge clk) ext_div <= ext_div + 2'h1;

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    // queue one word and load it, high part first
    task automatic tx_word(input logic [8:0] d);
        tx_q.push_back({1'b1, d});
        wr_reg(asu_pkg::ADDR_TXBUF_HI, {7'h00, d[8]});
        wr_reg(asu_pkg::ADDR_TXBUF_LO, d[7:0]);
    endtask : tx_word
    task automatic wait_txi();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (tx_irq !== 1'b1 && i < 2000);
        chk(10'(tx_irq), 10'h001);
    endtask : wait_txi
    // peer sends; request-to-send must stand high mid-frame
    task automatic rx_frame(input logic [8:0] d, input logic bp,
                            input logic bs);
        fork
            peer_u.send(d, bp, bs);
            begin
                repeat (40) @(posedge clk);
                chk(rts, 1'b1);
            end
        join
    endtask : rx_frame
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // watcher: read data, decoded frames, pulse bookkeeping, timeout
    always @(posedge clk) begin
        rd_seen <= rd;
        cyc <= cyc + 1;
        if (rd_seen === 1'b1) chk({2'b00, rdata}, {2'b00, rd_q.pop_front()});
        if (got === 1'b1) chk(got_word, tx_q.pop_front());
        if (rx_irq === 1'b1) n_rxi <= n_rxi + 1;
        if (tx_irq === 1'b1) begin
            txi_gap <= cyc - txi_at;
            txi_at <= cyc;
        end
        if (cyc > LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin : main
        logic [8:0] d;
        int p;
        int i;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(asu_pkg::ADDR_MODE, 8'h00);
        rd_reg(asu_pkg::ADDR_CTRL0, 8'h08);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'h02);
        rd_reg(asu_pkg::ADDR_TXBUF_LO, 8'h00);
        // each format: one received word, two sent back to back
        for (int k = 0; k < 4; k++) begin
            fmt <= FMTS[k];
            // external source ticks every 4 clocks: peer divisor 4
            brg <= FMTS[k][asu_pkg::MODE_EXT_CLK] ? 8'h03 : BRGS[k];
            wr_reg(asu_pkg::ADDR_MODE, FMTS[k]);
            wr_reg(asu_pkg::ADDR_BRG, BRGS[k]);
            wr_reg(asu_pkg::ADDR_CTRL0, 8'h04);
            wr_reg(asu_pkg::ADDR_CTRL1, 8'h04);
            repeat (3) @(posedge clk);
            chk(rts, 1'b0);
            chk(rts_oe, 1'b1);
            d = 9'(rnd()) & MASKS[k];
            p = n_rxi;
            rx_frame(d, 1'b0, 1'b0);
            repeat (4) @(posedge clk);
            chk(10'(n_rxi), 10'(p + 1));
            rd_reg(asu_pkg::ADDR_CTRL1, 8'h0E);
            rd_reg(asu_pkg::ADDR_RXBUF_LO, d[7:0]);
            rd_reg(asu_pkg::ADDR_RXBUF_HI, {7'h00, d[8]});
            rd_reg(asu_pkg::ADDR_CTRL1, 8'h06);
            chk(rts, 1'b0);
            cts <= 1'b1;
            wr_reg(asu_pkg::ADDR_CTRL0, 8'h00);
            wr_reg(asu_pkg::ADDR_CTRL1, 8'h05);
            tx_word(9'(rnd()) & MASKS[k]);
            repeat (40) @(posedge clk);
            chk(sout, 1'b1);
            rd_reg(asu_pkg::ADDR_CTRL1, 8'h05);
            cts <= 1'b0;
            wait_txi();
            tx_word(9'(rnd()) & MASKS[k]);
            rd_reg(asu_pkg::ADDR_CTRL0, 8'h00);
            wait_txi();
            cts <= 1'b1;
            wr_reg(asu_pkg::ADDR_CTRL1, 8'h04);
            i = 0;
            while (tx_q.size() != 0 && i < 3000) begin
                @(posedge clk);
                i++;
            end
            chk(10'(tx_q.size()), 10'h000);
            // peer reports at mid stop; let the last stop bit run out
            repeat (48) @(posedge clk);
            rd_reg(asu_pkg::ADDR_CTRL0, 8'h08);
            if (FMTS[k][asu_pkg::MODE_EXT_CLK]) begin
                // first tick after an idle start lags by up to 4 clocks
                chk(10'((txi_gap + 3) / 4), 10'(FLEN[k] / 4));
            end else begin
                chk(10'(txi_gap), 10'(FLEN[k]));
            end
        end
        // receive errors and their clearing
        fmt <= FMTS[0];
        brg <= BRGS[0];
        wr_reg(asu_pkg::ADDR_MODE, FMTS[0]);
        wr_reg(asu_pkg::ADDR_BRG, BRGS[0]);
        wr_reg(asu_pkg::ADDR_CTRL0, 8'h04);
        rx_frame(9'h03C, 1'b0, 1'b0);
        rx_frame(9'h05A, 1'b1, 1'b0);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'hDE);
        rd_reg(asu_pkg::ADDR_RXBUF_LO, 8'h5A);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'h06);
        rx_frame(9'h0C3, 1'b0, 1'b1);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'hAE);
        wr_reg(asu_pkg::ADDR_CTRL1, 8'h00);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'h02);
        wr_reg(asu_pkg::ADDR_CTRL1, 8'h04);
        // sleep: top bit low dropped, top bit high kept
        wr_reg(asu_pkg::ADDR_MODE, 8'hF5);
        p = n_rxi;
        rx_frame(9'h055, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk(10'(n_rxi), 10'(p));
        rd_reg(asu_pkg::ADDR_CTRL1, 8'h06);
        rx_frame(9'h0D5, 1'b0, 1'b0);
        rd_reg(asu_pkg::ADDR_CTRL1, 8'h0E);
        rd_reg(asu_pkg::ADDR_RXBUF_LO, 8'hD5);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule : tb
